/* File: wdtu_counter.sv */
// Purpose: two-stage binary counter behind the prescale divider
// Assumes: tick_i is a one-cycle pulse at the prescale carry
// Notes: the overflow pulse marks the falling edge of the top stage
`default_nettype none
module wdtu_counter (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic clear_i,
    output logic ovf_o
);
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic ovf_next;
    always_comb begin
        cnt_next = cnt_reg;
        ovf_next = 1'b0;
        if (clear_i) begin
            cnt_next = 2'h0;
        end else if (tick_i) begin
            cnt_next = cnt_reg + 2'h1;
            ovf_next = (cnt_reg == 2'h3);
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 2'h0;
            ovf_o <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            ovf_o <= ovf_next;
        end
    end
endmodule : wdtu_counter
`default_nettype wire

/* File: wdtu_pkg.sv */
// Purpose: shared constants and types for the watchdog timer unit
// Assumes: 20 MHz mclk_i, registers on a plain strobe port
// Notes: addresses are word indices on the register port
`default_nettype none
package wdtu_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [1:0] ADDR_CONFIG = 2'h0;
    localparam logic [1:0] ADDR_COMMAND = 2'h1;
    localparam logic [1:0] ADDR_STATUS = 2'h2;
    // config register fields
    localparam int CFG_PERIOD_LSB = 1;
    localparam int CFG_ACTION_BIT = 0;
    localparam int CFG_ENABLE_BIT = 3;
    localparam logic [7:0] CFG_RESET_VAL = 8'h09;
    // command codes
    localparam logic [7:0] CMD_CLEAR = 8'h4E;
    localparam logic [7:0] CMD_DISABLE = 8'hB1;
    // divider and counter widths: fast clock periods 2^25..2^19, slow 2^17..2^11
    localparam int DIV_FAST_W = 23;
    localparam int DIV_SLOW_W = 15;
    localparam int RST_OUT_LOG2 = 20;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } wdtu_bus_req_t;
    typedef struct packed {
        logic stop_mode;
        logic idle_mode;
        logic slow_clock;
        logic slow_tick;
    } wdtu_mode_t;
    typedef enum logic [2:0] {
        WDTU_ST_IDLE = 3'b001,
        WDTU_ST_RESET = 3'b010,
        WDTU_ST_IRQ = 3'b100
    } wdtu_state_t;
endpackage : wdtu_pkg
`default_nettype wire

/* File: wdtu_properties.sv */
// Purpose: port assertions for the watchdog timer unit
// Assumes: one clock, async active-low reset
// Notes: bound to wdtu_top below
`default_nettype none
module wdtu_checker
    import wdtu_pkg::*;
#(
    parameter int RST_OUT_CYCLES = 1 << RST_OUT_LOG2
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic stop_mode_i,
    input wire logic idle_mode_i,
    input wire logic wdog_irq_o,
    input wire logic sys_reset_n_o,
    input wire logic sys_reset_n_oe_o,
    input wire logic fast_osc_on_o
);
    int unsigned oe_cnt_reg;
    int unsigned oe_cnt_next;
    logic clr_w;
    assign clr_w = wr_i && addr_i == ADDR_COMMAND && wdata_i == CMD_CLEAR;
    always_comb begin
        oe_cnt_next = sys_reset_n_oe_o ? oe_cnt_reg + 1 : 0;
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            oe_cnt_reg <= 0;
        end else begin
            oe_cnt_reg <= oe_cnt_next;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    AST_IRQ_PULSE: assert property (wdog_irq_o |=> !wdog_irq_o)
        else $error("irq longer than one cycle");
    AST_ONE_ACTION: assert property (!(wdog_irq_o && sys_reset_n_oe_o))
        else $error("irq and reset together");
    AST_PIN_LOW: assert property (sys_reset_n_oe_o |-> !sys_reset_n_o)
        else $error("pin driven but not low");
    AST_PIN_IDLE: assert property (!sys_reset_n_oe_o |-> sys_reset_n_o)
        else $error("pin low while released");
    AST_OSC_ON: assert property (sys_reset_n_oe_o |-> fast_osc_on_o)
        else $error("oscillator off during reset out");
    AST_RST_LEN: assert property ($fell(sys_reset_n_oe_o) |-> oe_cnt_reg == RST_OUT_CYCLES)
        else $error("reset output length wrong");
    AST_RST_MAX: assert property (sys_reset_n_oe_o |-> oe_cnt_reg < RST_OUT_CYCLES)
        else $error("reset output too long");
    AST_PAUSE: assert property ((stop_mode_i || idle_mode_i)[*8] |=> !wdog_irq_o && !$rose(sys_reset_n_oe_o))
        else $error("event while paused");
    AST_CLEAR: assert property (clr_w |-> ##2 (!wdog_irq_o && !$rose(sys_reset_n_oe_o))[*6])
        else $error("event right after clear");
    COV_IRQ: cover property (wdog_irq_o);
    COV_RST: cover property ($rose(sys_reset_n_oe_o));
    COV_CLR: cover property (clr_w);
endmodule : wdtu_checker
bind wdtu_top wdtu_checker #(.RST_OUT_CYCLES(RST_OUT_CYCLES)) wdtu_checker_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .stop_mode_i(stop_mode_i), .idle_mode_i(idle_mode_i),
    .wdog_irq_o(wdog_irq_o), .sys_reset_n_o(sys_reset_n_o), .sys_reset_n_oe_o(sys_reset_n_oe_o),
    .fast_osc_on_o(fast_osc_on_o));
`default_nettype wire

/* File: wdtu_sync.sv */
// Purpose: two-flop synchroniser for one level
// Assumes: async input, single clock
// Notes: first flop read only by the second
`default_nettype none
module wdtu_sync (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_reg;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end
endmodule : wdtu_sync
`default_nettype wire

/* File: wdtu_tb_top.sv */
// Purpose: self-checking bench for the watchdog timer unit
// Assumes: slow tick toggles every cycle, period 3 is 4096 cycles
// Notes: reset output shortened to 16 cycles
`default_nettype none
module wdtu_tb_top;
    import wdtu_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0, rd_i = 1'b0, stop_mode_i = 1'b0, idle_mode_i = 1'b0, slow_clock_i = 1'b0;
    logic dual_clock_mode_i = 1'b0, slow_tick_i = 1'b0, irq_return_instr_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic wdog_irq_o, sys_reset_n_o, sys_reset_n_oe_o, fast_osc_on_o;
    int error_cnt = 0;
    int total_checks = 0;
    always #25 mclk_i = !mclk_i;
    always @(posedge mclk_i) slow_tick_i <= !slow_tick_i;
    wdtu_top #(.RST_OUT_CYCLES(16)) wdtu_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stop_mode_i(stop_mode_i),
        .idle_mode_i(idle_mode_i), .dual_clock_mode_i(dual_clock_mode_i), .slow_clock_i(slow_clock_i),
        .slow_tick_i(slow_tick_i), .irq_return_instr_i(irq_return_instr_i), .wdog_irq_o(wdog_irq_o),
        .sys_reset_n_o(sys_reset_n_o), .sys_reset_n_oe_o(sys_reset_n_oe_o), .fast_osc_on_o(fast_osc_on_o));
    task automatic report_and_stop;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask : chk
    task automatic do_reset;
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (16) @(posedge mclk_i);
        rst_n_i <= 1'b1;
    endtask : do_reset
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] m,
        input string msg);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk((rdata_o & m) === exp, msg);
    endtask : rd
    task automatic run(input int n, input logic want, input string msg);
        int i;
        for (i = 0; i < n; i++) begin
            @(negedge mclk_i);
            if (wdog_irq_o === 1'b1 || sys_reset_n_oe_o === 1'b1) break;
        end
        chk(want === (i < n), msg);
        if (want && i == n) report_and_stop();
    endtask : run
    initial begin
        do_reset();
        rd(ADDR_CONFIG, CFG_RESET_VAL, 8'hFF, "config reset value");
        rd(ADDR_STATUS, 8'h01, 8'h01, "not running after reset");
        rd(2'h3, 8'h00, 8'hFF, "unmapped read not zero");
        wr(ADDR_COMMAND, CMD_DISABLE);
        rd(ADDR_STATUS, 8'h01, 8'h01, "stopped while enabled");
        slow_clock_i <= 1'b1;
        wr(ADDR_CONFIG, 8'h0F);
        repeat (3) begin
            wr(ADDR_COMMAND, CMD_CLEAR);
            run(2000, 1'b0, "overflow before three quarters");
        end
        wr(ADDR_COMMAND, CMD_CLEAR);
        run(1500, 1'b0, "early overflow");
        wr(ADDR_COMMAND, 8'h55);
        stop_mode_i <= 1'b1;
        run(3000, 1'b0, "counted in stop");
        @(posedge mclk_i);
        stop_mode_i <= 1'b0;
        idle_mode_i <= 1'b1;
        run(3000, 1'b0, "counted in idle");
        @(posedge mclk_i);
        idle_mode_i <= 1'b0;
        run(1500, 1'b0, "overflow too soon");
        run(1300, 1'b1, "no overflow");
        chk(sys_reset_n_oe_o === 1'b1 && sys_reset_n_o === 1'b0 && fast_osc_on_o === 1'b1, "no reset out");
        repeat (16) @(negedge mclk_i);
        chk(sys_reset_n_oe_o === 1'b0 && sys_reset_n_o === 1'b1, "reset out length");
        do_reset();
        wr(ADDR_CONFIG, 8'h0A);
        wr(ADDR_CONFIG, 8'h0F);
        rd(ADDR_CONFIG, 8'h0E, 8'hFF, "action select not locked");
        wr(ADDR_COMMAND, CMD_CLEAR);
        run(3000, 1'b0, "early interrupt");
        run(1300, 1'b1, "no interrupt");
        chk(wdog_irq_o === 1'b1 && sys_reset_n_oe_o === 1'b0, "action not locked");
        run(5000, 1'b0, "interrupt while in service");
        @(posedge mclk_i);
        irq_return_instr_i <= 1'b1;
        @(posedge mclk_i);
        irq_return_instr_i <= 1'b0;
        run(20, 1'b1, "interval interrupt lost");
        wr(ADDR_CONFIG, 8'h00);
        wr(ADDR_COMMAND, CMD_DISABLE);
        rd(ADDR_STATUS, 8'h00, 8'h01, "not disabled");
        run(5000, 1'b0, "event while disabled");
        report_and_stop();
    end
endmodule : wdtu_tb_top
`default_nettype wire

/* File: wdtu_top.sv */
// Contract
// - overflow action chosen once after reset
// - interval timer interrupt when not supervising
// - overflow asserts output unless cleared first
// - select 1 gives reset pulse low
// - select 0 gives watchdog interrupt request
// - stop and idle pause counting, hold count
// - code 4E clears counter, not divider
// - four detection periods, fast or slow
// - enable bit 3 runs the watchdog
// - reset sets enable bit to one
// - disable needs enable cleared then B1
// - B1 while enabled is ignored
// - disabled holds counter stages at zero
// - interrupt unmasked, waits for return
// - reset output low for 2^20 cycles
//
// Purpose: watchdog timer with config and command registers
// Assumes: mode inputs and slow tick come from outside the clock domain
// Notes: mclk_i stands for the fast clock; slow_tick_i marks fs edges
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`default_nettype none
module wdtu_top #(
    parameter int RST_OUT_CYCLES = 1 << wdtu_pkg::RST_OUT_LOG2
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [wdtu_pkg::ADDR_W-1:0] addr_i,
    input wire logic [wdtu_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [wdtu_pkg::DATA_W-1:0] rdata_o,
    input wire logic stop_mode_i,
    input wire logic idle_mode_i,
    input wire logic dual_clock_mode_i,
    input wire logic slow_clock_i,
    input wire logic slow_tick_i,
    input wire logic irq_return_instr_i,
    output logic wdog_irq_o,
    output logic sys_reset_n_o,
    output logic sys_reset_n_oe_o,
    output logic fast_osc_on_o
);
    import wdtu_pkg::*;

    wdtu_mode_t mode;
    logic stop_s, idle_s, slow_s, stick_s, stick_d_reg;
    logic dual_s, ret_s;
    wdtu_sync u_sync_stop (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(stop_mode_i), .q_o(stop_s));
    wdtu_sync u_sync_idle (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(idle_mode_i), .q_o(idle_s));
    wdtu_sync u_sync_slow (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(slow_clock_i), .q_o(slow_s));
    wdtu_sync u_sync_tick (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(slow_tick_i), .q_o(stick_s));
    wdtu_sync u_sync_dual (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(dual_clock_mode_i), .q_o(dual_s));
    wdtu_sync u_sync_ret (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .d_i(irq_return_instr_i), .q_o(ret_s));

    // registers
    logic [1:0] period_reg, period_next;
    logic action_reg, action_next;
    logic action_locked_reg, action_locked_next;
    logic enable_reg, enable_next;
    logic running_reg, running_next;
    logic [DIV_FAST_W-1:0] div_reg, div_next;
    logic [DATA_W-1:0] rdata_next;
    logic irq_next;
    logic irq_pend_reg, irq_pend_next;
    logic in_service_reg, in_service_next;
    logic rst_out_reg, rst_out_next;
    logic [20:0] rst_len_reg, rst_len_next;
    wdtu_state_t state_reg, state_next;

    logic wr_cfg, wr_cmd, counting, cnt_clear, ovf, tick, slow_edge;
    logic [4:0] tap;

    always_comb begin
        mode.stop_mode = stop_s;
        mode.idle_mode = idle_s;
        mode.slow_clock = slow_s;
        mode.slow_tick = stick_s;
    end

    assign wr_cfg = wr_i && (addr_i == ADDR_CONFIG);
    assign wr_cmd = wr_i && (addr_i == ADDR_COMMAND);
    assign slow_edge = mode.slow_tick && !stick_d_reg;
    assign counting = running_reg && !mode.stop_mode && !mode.idle_mode;
    assign cnt_clear = !running_reg || (wr_cmd && wdata_i == CMD_CLEAR);

    // divider tap: binary counter steps at a quarter of the period
    always_comb begin
        tap = 5'h0;
        if (mode.slow_clock) begin
            tap = 5'(DIV_SLOW_W - 2 * int'(period_reg) - 1);
        end else begin
            tap = 5'(DIV_FAST_W - 2 * int'(period_reg) - 1);
        end
    end

    // divider advances on fast clock, or on fs edges in slow operation
    always_comb begin
        div_next = div_reg;
        tick = 1'b0;
        if (counting && (!mode.slow_clock || slow_edge)) begin
            div_next = div_reg + 1'b1;
            tick = (div_reg[tap] == 1'b1) && (div_next[tap] == 1'b0);
        end else if (!running_reg) begin
            div_next = '0;
        end
    end

    wdtu_counter u_counter (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick),
        .clear_i(cnt_clear),
        .ovf_o(ovf)
    );

    // config and command decode
    always_comb begin
        period_next = period_reg;
        action_next = action_reg;
        action_locked_next = action_locked_reg;
        enable_next = enable_reg;
        running_next = running_reg;
        if (wr_cfg) begin
            period_next = wdata_i[CFG_PERIOD_LSB +: 2];
            enable_next = wdata_i[CFG_ENABLE_BIT];
            if (wdata_i[CFG_ENABLE_BIT]) begin
                running_next = 1'b1;
            end
            if (!action_locked_reg) begin
                action_next = wdata_i[CFG_ACTION_BIT];
                action_locked_next = 1'b1;
            end
        end
        if (wr_cmd && wdata_i == CMD_DISABLE && !enable_reg) begin
            running_next = 1'b0;
        end
        // any other command code falls through untouched
    end

    // overflow action sequencer
    always_comb begin
        state_next = state_reg;
        irq_next = 1'b0;
        irq_pend_next = irq_pend_reg;
        in_service_next = in_service_reg;
        rst_out_next = rst_out_reg;
        rst_len_next = rst_len_reg;
        if (ret_s) begin
            in_service_next = 1'b0;
        end
        case (state_reg)
            WDTU_ST_IDLE: begin
                if (ovf && running_reg) begin
                    if (action_reg) begin
                        state_next = WDTU_ST_RESET;
                        rst_out_next = 1'b1;
                        rst_len_next = 21'(RST_OUT_CYCLES - 1);
                    end else begin
                        irq_pend_next = 1'b1;
                    end
                end
                if (irq_pend_reg && !in_service_reg) begin
                    irq_next = 1'b1;
                    irq_pend_next = ovf && running_reg && !action_reg;
                    in_service_next = 1'b1;
                end
            end
            WDTU_ST_RESET: begin
                if (rst_len_reg == 21'h0) begin
                    rst_out_next = 1'b0;
                    state_next = WDTU_ST_IDLE;
                end else begin
                    rst_len_next = rst_len_reg - 21'h1;
                end
            end
            default: begin
                state_next = WDTU_ST_IDLE;
            end
        endcase
    end

    // read mux
    always_comb begin
        rdata_next = '0;
        if (rd_i) begin
            case (addr_i)
                ADDR_CONFIG: begin
                    rdata_next[CFG_PERIOD_LSB +: 2] = period_reg;
                    rdata_next[CFG_ACTION_BIT] = action_reg;
                    rdata_next[CFG_ENABLE_BIT] = enable_reg;
                end
                ADDR_STATUS: begin
                    rdata_next = {3'h0, dual_s, action_locked_reg, rst_out_reg, in_service_reg, running_reg};
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            period_reg <= 2'h0;
            action_reg <= 1'b1;
            action_locked_reg <= 1'b0;
            enable_reg <= 1'b1;
            running_reg <= 1'b1;
            div_reg <= '0;
            stick_d_reg <= 1'b0;
            state_reg <= WDTU_ST_IDLE;
            irq_pend_reg <= 1'b0;
            in_service_reg <= 1'b0;
            rst_out_reg <= 1'b0;
            rst_len_reg <= 21'h0;
            rdata_o <= '0;
        end else begin
            period_reg <= period_next;
            action_reg <= action_next;
            action_locked_reg <= action_locked_next;
            enable_reg <= enable_next;
            running_reg <= running_next;
            div_reg <= div_next;
            stick_d_reg <= mode.slow_tick;
            state_reg <= state_next;
            irq_pend_reg <= irq_pend_next;
            in_service_reg <= in_service_next;
            rst_out_reg <= rst_out_next;
            rst_len_reg <= rst_len_next;
            rdata_o <= rdata_next;
        end
    end

    // open-drain reset pin: enable high drives pin low
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sys_reset_n_o <= 1'b1;
            sys_reset_n_oe_o <= 1'b0;
            fast_osc_on_o <= 1'b0;
            wdog_irq_o <= 1'b0;
        end else begin
            sys_reset_n_o <= !rst_out_next;
            sys_reset_n_oe_o <= rst_out_next;
            fast_osc_on_o <= rst_out_next;
            wdog_irq_o <= irq_next;
        end
    end
endmodule : wdtu_top
`default_nettype wire
